// ===== hw/pbc_defines.svh
// Purpose: constants of the peripheral bus configuration and control block
// Assumes: byte addresses on the host side, 32-bit register words
// Notes:   multi-bit field positions are written as hi:lo ranges, single-bit fields as one index
`ifndef PBC_DEFINES_SVH
`define PBC_DEFINES_SVH
// ============================================================
// address decode
`define PBC_REGION        23:22
`define PBC_REGION_ROM    2'h0
`define PBC_REGION_BBRAM  2'h1
`define PBC_REGION_PIO    2'h2
`define PBC_REGION_INT    2'h3
`define PBC_ROM_SEL_BIT   21
`define PBC_ROM_ADDR      20:1
`define PBC_BBRAM_ADDR    16:2
`define PBC_PIO_CH        13:10
`define PBC_PIO_REG       9:2
`define PBC_GRP           13:10
`define PBC_IDX           9:6
`define PBC_GRP_DCFG      4'h0
`define PBC_GRP_DCTRL     4'h1
`define PBC_GRP_PCFG      4'h2
`define PBC_GRP_ROM_WE    4'h3
`define PBC_GRP_ROM_SWAP  4'h4
`define PBC_GRP_GEN_OUT   4'h5
// ============================================================
// configuration fields; timing, wide and even high shared by dma and pio, real time, burst and live dma only
`define PBC_CFG_RD_SHORT  0
`define PBC_CFG_RD_MID    4:1
`define PBC_CFG_RD_LATE   8:5
`define PBC_CFG_WR_SHORT  9
`define PBC_CFG_WR_MID    13:10
`define PBC_CFG_WR_LATE   17:14
`define PBC_CFG_WIDE      18
`define PBC_CFG_EVEN_HIGH 19
`define PBC_CFG_REAL_TIME 21
`define PBC_CFG_BURST     26:22
`define PBC_CFG_LIVE      27
// ============================================================
// control write and read fields
`define PBC_CTL_LITTLE    1
`define PBC_CTL_RECEIVE   2
`define PBC_CTL_FLUSH     3
`define PBC_CTL_RUN       4
`define PBC_CTL_RUN_GATE  5
`define PBC_CTL_RT        6
`define PBC_CTL_HIGHWATER 15:8
`define PBC_CTL_FIFO_BEG  21:16
`define PBC_CTL_FIFO_END  29:24
`define PBC_CTL_RD_IRQ    0
`define PBC_CTL_RD_RUN    1
`define PBC_FIFO_LAST_ROW 6'h2f
// ============================================================
// cycle counts
`define PBC_CYC_ZERO      5'h10
`define PBC_CYC_ONE       5'h01
`define PBC_CYC_TWO       5'h02
`define PBC_CYC_THREE     5'h03
`endif

// ===== hw/pbc_pkg.sv
// Purpose: types of the peripheral bus configuration and control block
// Assumes: constants live in pbc_defines.svh
// Notes:   counts are in host clock cycles
package pbc_pkg;
    // ============================================================
    // decoded state lengths
    typedef struct packed {
        logic [4:0] rd_second;
        logic [4:0] rd_third;
        logic [4:0] rd_fourth;
        logic [4:0] wr_second;
        logic [4:0] wr_third;
        logic [4:0] wr_fourth;
    } pbc_timing_type;
    // ============================================================
    // per dma channel settings
    typedef struct packed {
        pbc_timing_type timing;
        logic           wide_device_flag;
        logic           even_high;
        logic           real_time;
        logic [4:0]     burst;
        logic           little;
        logic           receive;
        logic           flush;
        logic           channel_running;
        logic           rt_service;
        logic [5:0]     fifo_beg;
        logic [5:0]     fifo_end;
        logic           fifo_ok;
    } pbc_dma_chan_type;
    typedef enum logic {PBC_ST_IDLE, PBC_ST_EXT} pbc_state_type;
endpackage : pbc_pkg

// ===== hw/pbc_ctrl.sv
// Purpose: register file and decode of a peripheral bus controller
// Assumes: one host clock, synchronous active high reset
// Notes:   read answers leave through a two-entry buffer
`timescale 1ns/10ps
`default_nettype none
`include "pbc_defines.svh"
// ============================================================
// top module
module pbc_ctrl #(
    parameter int DMA_CH = 8,
    parameter int PIO_CH = 10
) (
    input  wire logic                     clock_in,
    input  wire logic                     srst_in,
    input  wire logic                     reg_valid_in,
    output logic                          reg_ready_out,
    input  wire logic                     reg_write_in,
    input  wire logic [23:0]              reg_addr_in,
    input  wire logic [31:0]              reg_wdata_in,
    output logic                          rsp_valid_out,
    input  wire logic                     rsp_ready_in,
    output logic [31:0]                   rsp_data_out,
    output logic                          ext_strobe_out,
    output logic                          ext_write_out,
    output logic [19:0]                   ext_addr_out,
    output logic [15:0]                   ext_wdata_out,
    input  wire logic [15:0]              ext_rdata_in,
    input  wire logic                     ext_ack_in,
    output logic [PIO_CH-1:0]             pio_cs_out,
    output logic                          bbram_cs_out,
    output logic [1:0]                    rom_cs_out,
    output pbc_pkg::pbc_timing_type       ext_timing_out,
    input  wire logic [DMA_CH-1:0]        dma_req_n_in,
    output logic [DMA_CH-1:0]             dma_preempt_out,
    input  wire logic [DMA_CH-1:0][7:0]   dma_level_in,
    output logic [DMA_CH-1:0]             dma_service_out,
    input  wire logic [DMA_CH-1:0]        dma_done_in,
    input  wire logic [DMA_CH-1:0]        dma_buf_irq_in,
    output pbc_pkg::pbc_dma_chan_type [DMA_CH-1:0] dma_chan_out,
    input  wire logic                     dma_tc_req_in,
    input  wire logic                     tc_in,
    output logic                          tc_out,
    output logic                          tc_oe_out,
    output logic                          spare_out
);
    // ============================================================
    // declarations
    pbc_pkg::pbc_state_type state_q;
    logic [31:0]            dcfg_q [DMA_CH];
    logic [31:0]            dctl_q [DMA_CH];
    logic [31:0]            pcfg_q [PIO_CH];
    logic [DMA_CH-1:0]      run_q;
    logic [DMA_CH-1:0]      irq_q;
    logic [DMA_CH-1:0]      sync1_q;
    logic [DMA_CH-1:0]      sync2_q;
    logic [DMA_CH-1:0]      sync_prev_q;
    logic [DMA_CH-1:0]      live_prev_q;
    logic                   rom_we_q;
    logic                   rom_swap_q;
    logic                   spare_q;
    logic                   tc_q;
    logic                   tc_oe_q;
    logic                   ext_strobe_q;
    logic                   ext_write_q;
    logic [19:0]            ext_addr_q;
    logic [15:0]            ext_wdata_q;
    logic [PIO_CH-1:0]      pio_cs_q;
    logic                   bbram_cs_q;
    logic [1:0]             rom_cs_q;
    logic                   ext_wide_q;
    logic                   ext_high_q;
    pbc_pkg::pbc_timing_type ext_timing_q;
    logic [31:0]            buf_q [2];
    logic                   buf_wr_q;
    logic                   buf_rd_q;
    logic [1:0]             buf_cnt_q;
    logic                   accept;
    logic                   is_int;
    logic [3:0]             grp;
    logic [3:0]             idx;
    logic [3:0]             pio_ch;
    logic                   rom_hi;
    logic [31:0]            int_rdata;
    logic                   push;
    logic [31:0]            push_data;
    logic                   pop;
    logic [15:0]            ext_rd_steer;
    pbc_pkg::pbc_timing_type sel_timing;
    logic                   sel_wide;
    logic                   sel_high;

    function automatic logic [4:0] pbc_cyc16(input logic [3:0] v);
        pbc_cyc16 = (v == 4'h0) ? `PBC_CYC_ZERO : {1'b0, v};
    endfunction : pbc_cyc16

    function automatic pbc_pkg::pbc_timing_type pbc_dma_tim(input logic [31:0] c);
        pbc_dma_tim.rd_second = c[`PBC_CFG_RD_SHORT] ? `PBC_CYC_THREE : `PBC_CYC_TWO;
        pbc_dma_tim.wr_second = c[`PBC_CFG_WR_SHORT] ? `PBC_CYC_THREE : `PBC_CYC_TWO;
        pbc_dma_tim.rd_third  = pbc_cyc16(c[`PBC_CFG_RD_MID]);
        pbc_dma_tim.rd_fourth = pbc_cyc16(c[`PBC_CFG_RD_LATE]);
        pbc_dma_tim.wr_third  = pbc_cyc16(c[`PBC_CFG_WR_MID]);
        pbc_dma_tim.wr_fourth = pbc_cyc16(c[`PBC_CFG_WR_LATE]);
    endfunction : pbc_dma_tim

    function automatic pbc_pkg::pbc_timing_type pbc_pio_tim(input logic [31:0] c);
        pbc_pio_tim.rd_second = c[`PBC_CFG_RD_SHORT] ? `PBC_CYC_ONE : `PBC_CYC_TWO;
        pbc_pio_tim.wr_second = c[`PBC_CFG_WR_SHORT] ? `PBC_CYC_ONE : `PBC_CYC_TWO;
        pbc_pio_tim.rd_third  = pbc_cyc16(c[`PBC_CFG_RD_MID]);
        pbc_pio_tim.rd_fourth = pbc_cyc16(c[`PBC_CFG_RD_LATE]);
        pbc_pio_tim.wr_third  = pbc_cyc16(c[`PBC_CFG_WR_MID]);
        pbc_pio_tim.wr_fourth = pbc_cyc16(c[`PBC_CFG_WR_LATE]);
    endfunction : pbc_pio_tim

    // ============================================================
    // request decode
    assign reg_ready_out = (state_q == pbc_pkg::PBC_ST_IDLE) && (buf_cnt_q != 2'h2);
    assign accept        = reg_valid_in && reg_ready_out;
    assign is_int        = reg_addr_in[`PBC_REGION] == `PBC_REGION_INT;
    assign grp           = reg_addr_in[`PBC_GRP];
    assign idx           = reg_addr_in[`PBC_IDX];
    assign pio_ch        = reg_addr_in[`PBC_PIO_CH];
    assign rom_hi        = reg_addr_in[`PBC_ROM_SEL_BIT] ^ rom_swap_q;

    always_comb begin
        sel_timing = pbc_pio_tim(32'h0000_0000);
        sel_wide   = 1'b1;
        sel_high   = 1'b0;
        if (reg_addr_in[`PBC_REGION] == `PBC_REGION_PIO && pio_ch < 4'(PIO_CH)) begin
            sel_timing = pbc_pio_tim(pcfg_q[pio_ch]);
            sel_wide   = pcfg_q[pio_ch][`PBC_CFG_WIDE];
            sel_high   = pcfg_q[pio_ch][`PBC_CFG_EVEN_HIGH];
        end else if (reg_addr_in[`PBC_REGION] == `PBC_REGION_BBRAM) begin
            sel_wide   = 1'b0;
        end
    end

    always_comb begin
        int_rdata = 32'h0000_0000;
        unique case (grp)
            `PBC_GRP_DCFG: begin
                if (idx < 4'(DMA_CH)) begin
                    int_rdata = dcfg_q[idx[2:0]];
                end
            end
            `PBC_GRP_DCTRL: begin
                if (idx < 4'(DMA_CH)) begin
                    int_rdata[`PBC_CTL_RD_IRQ] = irq_q[idx[2:0]];
                    int_rdata[`PBC_CTL_RD_RUN] = run_q[idx[2:0]];
                end
            end
            `PBC_GRP_PCFG: begin
                if (idx < 4'(PIO_CH)) begin
                    int_rdata = pcfg_q[idx];
                end
            end
            default: begin
                int_rdata = 32'h0000_0000;
            end
        endcase
    end

    // ============================================================
    // access sequencer
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state_q <= pbc_pkg::PBC_ST_IDLE;
        end else begin
            unique case (state_q)
                pbc_pkg::PBC_ST_IDLE: begin
                    if (accept && !is_int
                        && !(reg_write_in && reg_addr_in[`PBC_REGION] == `PBC_REGION_ROM
                             && !rom_we_q)) begin
                        state_q <= pbc_pkg::PBC_ST_EXT;
                    end
                end
                pbc_pkg::PBC_ST_EXT: begin
                    if (ext_ack_in) begin
                        state_q <= pbc_pkg::PBC_ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            ext_strobe_q <= 1'b0;
            ext_write_q  <= 1'b0;
            ext_addr_q   <= 20'h0_0000;
            ext_wdata_q  <= 16'h0000;
            pio_cs_q     <= '0;
            bbram_cs_q   <= 1'b0;
            rom_cs_q     <= 2'h0;
            ext_wide_q   <= 1'b0;
            ext_high_q   <= 1'b0;
            ext_timing_q <= '0;
        end else if (state_q == pbc_pkg::PBC_ST_EXT) begin
            if (ext_ack_in) begin
                ext_strobe_q <= 1'b0;
                pio_cs_q     <= '0;
                bbram_cs_q   <= 1'b0;
                rom_cs_q     <= 2'h0;
            end
        end else if (accept && !is_int) begin
            ext_write_q  <= reg_write_in;
            ext_wide_q   <= sel_wide;
            ext_high_q   <= sel_high;
            ext_timing_q <= sel_timing;
            if (sel_wide) begin
                ext_wdata_q <= sel_high ? {reg_wdata_in[7:0], reg_wdata_in[15:8]}
                                        : reg_wdata_in[15:0];
            end else begin
                ext_wdata_q <= sel_high ? {reg_wdata_in[7:0], 8'h00}
                                        : {8'h00, reg_wdata_in[7:0]};
            end
            unique case (reg_addr_in[`PBC_REGION])
                `PBC_REGION_ROM: begin
                    if (!reg_write_in || rom_we_q) begin
                        ext_strobe_q <= 1'b1;
                        rom_cs_q     <= rom_hi ? 2'h2 : 2'h1;
                        ext_addr_q   <= reg_addr_in[`PBC_ROM_ADDR];
                    end
                end
                `PBC_REGION_BBRAM: begin
                    ext_strobe_q <= 1'b1;
                    bbram_cs_q   <= 1'b1;
                    ext_addr_q   <= {5'h00, reg_addr_in[`PBC_BBRAM_ADDR]};
                end
                default: begin
                    ext_strobe_q <= 1'b1;
                    if (pio_ch < 4'(PIO_CH)) begin
                        pio_cs_q[pio_ch] <= 1'b1;
                    end
                    ext_addr_q <= {4'h0, reg_addr_in[`PBC_PIO_REG],
                                   reg_addr_in[`PBC_PIO_REG]};
                end
            endcase
        end
    end

    assign ext_strobe_out = ext_strobe_q;
    assign ext_write_out  = ext_write_q;
    assign ext_addr_out   = ext_addr_q;
    assign ext_wdata_out  = ext_wdata_q;
    assign pio_cs_out     = pio_cs_q;
    assign bbram_cs_out   = bbram_cs_q;
    assign rom_cs_out     = rom_cs_q;
    assign ext_timing_out = ext_timing_q;

    // ============================================================
    // global bits and terminal count pin
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            rom_we_q <= 1'b0;
            spare_q  <= 1'b0;
        end else if (accept && is_int && reg_write_in) begin
            if (grp == `PBC_GRP_ROM_WE) begin
                rom_we_q <= reg_wdata_in[0];
            end
            if (grp == `PBC_GRP_GEN_OUT) begin
                spare_q <= reg_wdata_in[0];
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            rom_swap_q <= tc_in;
        end else if (accept && is_int && reg_write_in && grp == `PBC_GRP_ROM_SWAP) begin
            rom_swap_q <= reg_wdata_in[0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            tc_q    <= 1'b0;
            tc_oe_q <= 1'b0;
        end else begin
            tc_q    <= dma_tc_req_in;
            tc_oe_q <= 1'b1;
        end
    end

    assign tc_out    = tc_q;
    assign tc_oe_out = tc_oe_q;
    assign spare_out = spare_q;

    // ============================================================
    // pio configuration
    for (genvar p = 0; p < PIO_CH; p++) begin : g_pio
        always_ff @(posedge clock_in) begin
            if (srst_in) begin
                pcfg_q[p] <= 32'h0000_0000;
            end else if (accept && is_int && reg_write_in && grp == `PBC_GRP_PCFG
                         && idx == 4'(p)) begin
                pcfg_q[p] <= reg_wdata_in;
            end
        end
    end

    // ============================================================
    // dma channels
    for (genvar c = 0; c < DMA_CH; c++) begin : g_dma
        logic wr_cfg;
        logic wr_ctl;
        logic rd_ctl;
        assign wr_cfg = accept && is_int && reg_write_in && grp == `PBC_GRP_DCFG && idx == 4'(c);
        assign wr_ctl = accept && is_int && reg_write_in && grp == `PBC_GRP_DCTRL && idx == 4'(c);
        assign rd_ctl = accept && is_int && !reg_write_in && grp == `PBC_GRP_DCTRL
                        && idx == 4'(c);

        always_ff @(posedge clock_in) begin
            if (srst_in) begin
                dcfg_q[c] <= 32'h0000_0000;
                dctl_q[c] <= 32'h0000_0000;
            end else begin
                if (wr_cfg) begin
                    dcfg_q[c] <= reg_wdata_in;
                end
                if (wr_ctl) begin
                    dctl_q[c] <= reg_wdata_in;
                end
            end
        end

        always_ff @(posedge clock_in) begin
            if (srst_in) begin
                run_q[c] <= 1'b0;
            end else if (wr_ctl && reg_wdata_in[`PBC_CTL_RUN_GATE]) begin
                run_q[c] <= reg_wdata_in[`PBC_CTL_RUN];
            end else if (dma_done_in[c]) begin
                run_q[c] <= 1'b0;
            end
        end

        always_ff @(posedge clock_in) begin
            if (srst_in) begin
                irq_q[c] <= 1'b0;
            end else if (dma_buf_irq_in[c]) begin
                irq_q[c] <= 1'b1;
            end else if (rd_ctl) begin
                irq_q[c] <= 1'b0;
            end
        end

        always_ff @(posedge clock_in) begin
            if (srst_in) begin
                sync1_q[c]     <= 1'b1;
                sync2_q[c]     <= 1'b1;
                sync_prev_q[c] <= 1'b1;
                live_prev_q[c] <= 1'b1;
            end else begin
                sync1_q[c]     <= dma_req_n_in[c];
                sync2_q[c]     <= sync1_q[c];
                sync_prev_q[c] <= sync2_q[c];
                live_prev_q[c] <= dma_req_n_in[c];
            end
        end

        assign dma_preempt_out[c] = dcfg_q[c][`PBC_CFG_LIVE]
                                    ? (dma_req_n_in[c] && !live_prev_q[c])
                                    : (sync2_q[c] && !sync_prev_q[c]);
        assign dma_service_out[c] = run_q[c]
                                    && dma_level_in[c] >= dctl_q[c][`PBC_CTL_HIGHWATER];

        assign dma_chan_out[c].timing           = pbc_dma_tim(dcfg_q[c]);
        assign dma_chan_out[c].wide_device_flag = dcfg_q[c][`PBC_CFG_WIDE];
        assign dma_chan_out[c].even_high        = dcfg_q[c][`PBC_CFG_EVEN_HIGH];
        assign dma_chan_out[c].real_time        = dcfg_q[c][`PBC_CFG_REAL_TIME];
        assign dma_chan_out[c].burst            = dcfg_q[c][`PBC_CFG_BURST];
        assign dma_chan_out[c].little           = dctl_q[c][`PBC_CTL_LITTLE];
        assign dma_chan_out[c].receive          = dctl_q[c][`PBC_CTL_RECEIVE];
        assign dma_chan_out[c].flush            = dctl_q[c][`PBC_CTL_FLUSH];
        assign dma_chan_out[c].channel_running  = run_q[c];
        assign dma_chan_out[c].rt_service       = dctl_q[c][`PBC_CTL_RT];
        assign dma_chan_out[c].fifo_beg         = dctl_q[c][`PBC_CTL_FIFO_BEG];
        assign dma_chan_out[c].fifo_end         = dctl_q[c][`PBC_CTL_FIFO_END];
        assign dma_chan_out[c].fifo_ok          =
            dctl_q[c][`PBC_CTL_FIFO_BEG] <= dctl_q[c][`PBC_CTL_FIFO_END]
            && dctl_q[c][`PBC_CTL_FIFO_END] <= `PBC_FIFO_LAST_ROW;
    end

    // ============================================================
    // answer buffer
    assign ext_rd_steer = !ext_wide_q ? (ext_high_q ? {8'h00, ext_rdata_in[15:8]}
                                                    : {8'h00, ext_rdata_in[7:0]})
                        : (ext_high_q ? {ext_rdata_in[7:0], ext_rdata_in[15:8]}
                                      : ext_rdata_in);
    assign push      = (accept && is_int && !reg_write_in)
                    || (state_q == pbc_pkg::PBC_ST_EXT && ext_ack_in && !ext_write_q);
    assign push_data = (state_q == pbc_pkg::PBC_ST_EXT) ? {16'h0000, ext_rd_steer} : int_rdata;
    assign pop       = rsp_valid_out && rsp_ready_in;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            buf_q[0] <= 32'h0000_0000;
            buf_q[1] <= 32'h0000_0000;
            buf_wr_q <= 1'b0;
        end else if (push) begin
            buf_q[buf_wr_q] <= push_data;
            buf_wr_q        <= !buf_wr_q;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            buf_rd_q  <= 1'b0;
            buf_cnt_q <= 2'h0;
        end else begin
            if (pop) begin
                buf_rd_q <= !buf_rd_q;
            end
            buf_cnt_q <= buf_cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    assign rsp_valid_out = buf_cnt_q != 2'h0;
    assign rsp_data_out  = buf_q[buf_rd_q];
endmodule : pbc_ctrl
`default_nettype wire

// ===== tb/pbc_ctrl_asserts.sv
// Purpose: port checks. Assumes: one clock. Notes: bound below
`timescale 1ns/10ps
`default_nettype none
module pbc_ctrl_asserts #(parameter int DMA_CH = 8) (
    input wire logic clock_in, srst_in, reg_valid_in, reg_ready_out, reg_write_in,
    input wire logic rsp_valid_out, rsp_ready_in, ext_strobe_out, ext_write_out,
    input wire logic ext_ack_in, dma_tc_req_in, tc_out, tc_oe_out,
    input wire logic [23:0] reg_addr_in,
    input wire logic [31:0] rsp_data_out,
    input wire logic [DMA_CH-1:0] dma_req_n_in, dma_preempt_out, dma_service_out,
    input wire pbc_pkg::pbc_dma_chan_type [DMA_CH-1:0] dma_chan_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    a_busy_refuses: assert property (ext_strobe_out |-> !reg_ready_out)
        else $error("ready in access");
    a_ext_answer: assert property (ext_ack_in && ext_strobe_out && !ext_write_out
        |=> !ext_strobe_out && rsp_valid_out) else $error("no ext answer");
    a_int_answer: assert property (reg_valid_in && reg_ready_out && !reg_write_in
        && reg_addr_in[23:22] == 2'h3 |=> rsp_valid_out) else $error("no int answer");
    a_rsp_holds: assert property (rsp_valid_out && !rsp_ready_in
        |=> rsp_valid_out && $stable(rsp_data_out)) else $error("answer lost");
    a_tc_follows: assert property (!$past(srst_in) |-> tc_out == $past(dma_tc_req_in))
        else $error("tc late");
    a_tc_drives: assert property (!$past(srst_in) |-> tc_oe_out)
        else $error("tc not driven");
    a_preempt_cause: assert property (dma_preempt_out[0] |-> dma_req_n_in[0]
        || $past(dma_req_n_in[0]) || $past(dma_req_n_in[0], 2) || $past(dma_req_n_in[0], 3))
        else $error("preempt without release");
    a_service_run: assert property (dma_service_out[0] |-> dma_chan_out[0].channel_running)
        else $error("service while stopped");
endmodule : pbc_ctrl_asserts
bind pbc_ctrl pbc_ctrl_asserts #(.DMA_CH(DMA_CH)) chk_u (.*);
`default_nettype wire

// ===== tb/pbc_periph_model.sv
// Purpose: peripheral model. Assumes: ack after WAIT. Notes: data from address
`timescale 1ns/10ps
`default_nettype none
module pbc_periph_model #(parameter int WAIT = 2) (
    input  wire logic        clock_in, strobe_in,
    input  wire logic [19:0] addr_in,
    output logic             ack_out = 1'h0,
    output logic [15:0]      rdata_out = 16'h0000
);
    int n = 0;
    always @(posedge clock_in) begin
        n <= (strobe_in && !ack_out) ? n + 1 : 0;
        ack_out <= #1 strobe_in && !ack_out && n == WAIT;
        rdata_out <= #1 (n == WAIT) ? addr_in[15:0] ^ 16'h5a5a : ~rdata_out;
    end
endmodule : pbc_periph_model
`default_nettype wire

// ===== tb/pbc_ctrl_bench.sv
// Purpose: bench of pbc_ctrl. Assumes: 25 MHz clock. Notes: own handshake tasks
`timescale 1ns/10ps
`default_nettype none
module pbc_ctrl_bench;
    logic clock_in = '0, srst_in = '1, tc_in = '0, dma_tc_req_in = '0, ext_ack_in;
    logic reg_valid_in = '0, reg_write_in = '0, rsp_ready_in = '0, reg_ready_out;
    logic rsp_valid_out, ext_strobe_out, ext_write_out, bbram_cs_out, tc_out, tc_oe_out;
    logic spare_out;
    logic [23:0] reg_addr_in = '0;
    logic [31:0] reg_wdata_in = '0, rsp_data_out, rd;
    logic [19:0] ext_addr_out;
    logic [15:0] ext_wdata_out, ext_rdata_in;
    logic [9:0] pio_cs_out;
    logic [1:0] rom_cs_out;
    logic [2:0] cs;
    logic [7:0] dma_req_n_in = '1, dma_done_in = '0, dma_buf_irq_in = '0;
    logic [7:0] dma_preempt_out, dma_service_out;
    logic [7:0][7:0] dma_level_in = '0;
    pbc_pkg::pbc_timing_type ext_timing_out, tm;
    pbc_pkg::pbc_dma_chan_type [7:0] dma_chan_out;
    pbc_pkg::pbc_dma_chan_type c;
    int err_total = 0, comparisons = 0;
    pbc_ctrl dut_u (.*);
    pbc_periph_model per_u (.clock_in(clock_in), .strobe_in(ext_strobe_out),
        .addr_in(ext_addr_out), .ack_out(ext_ack_in), .rdata_out(ext_rdata_in));
    always #20 clock_in = ~clock_in;
    function automatic logic [23:0] ia(input logic [3:0] g, i, w);
        ia = {2'h3, 8'h00, g, i, w, 2'h0};
    endfunction : ia
    task automatic chk(input string nm, input logic [31:0] e, s);
        comparisons++;
        if (e !== s) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [23:0] a, input logic [31:0] d);
        @(posedge clock_in) #1;
        {reg_valid_in, reg_write_in, reg_addr_in, reg_wdata_in} = {1'h1, w, a, d};
        for (int i = 0; i < 50 && !reg_ready_out; i++) @(posedge clock_in) #1;
        chk("ready", 1, reg_ready_out);
        @(posedge clock_in) #1 reg_valid_in = 0;
        for (int i = 0; i < 50 && !w && !rsp_valid_out; i++) begin
            if (ext_strobe_out) {tm, cs} = {ext_timing_out, bbram_cs_out, rom_cs_out};
            @(posedge clock_in) #1;
        end
        if (!w) begin
            chk("rsp_valid", 1, rsp_valid_out);
            {rd, rsp_ready_in} = {rsp_data_out, 1'h1};
            @(posedge clock_in) #1 rsp_ready_in = 0;
        end
    endtask : acc
    task automatic end_of_test();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        #200000 err_total++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge clock_in);
        #1 srst_in = 0;
        chk("spare", 0, spare_out);
        acc(1, ia(0, 0, 0), 32'h07e4_1421);
        chk("tc_oe", 1, tc_oe_out);
        acc(0, ia(0, 0, 9), 0);
        c = dma_chan_out[0];
        chk("dcfg", 32'h07e4_1421, rd);
        chk("dtime", {5'h03, 5'h10, 5'h01, 5'h02, 5'h05, 5'h10}, c.timing);
        chk("dflag", 7'h7f, {c.wide_device_flag, c.real_time, c.burst});
        acc(1, ia(1, 1, 0), 32'h2f00_0b5e);
        c = dma_chan_out[1];
        chk("dctl", 5'h1d, {c.little, c.receive, c.flush, c.channel_running, c.rt_service});
        chk("fifo", 13'h005f, {c.fifo_beg, c.fifo_end, c.fifo_ok});
        acc(1, ia(1, 1, 0), 32'h2f00_0b7e);
        dma_level_in[1] = 8'h0a;
        #1 chk("svc_lo", 0, dma_service_out[1]);
        dma_level_in[1] = 8'h0b;
        #1 chk("svc_hi", 1, dma_service_out[1]);
        dma_buf_irq_in[1] = 1;
        @(posedge clock_in) #1 dma_buf_irq_in[1] = 0;
        acc(0, ia(1, 1, 3), 0);
        chk("irq", 3, rd);
        acc(0, ia(1, 1, 0), 0);
        chk("irq_clr", 2, rd);
        dma_done_in[1] = 1;
        @(posedge clock_in) #1 dma_done_in[1] = 0;
        {reg_valid_in, reg_addr_in} = {1'h1, ia(1, 1, 0)};
        repeat (2) @(posedge clock_in) #1;
        chk("full", 0, reg_ready_out);
        {reg_valid_in, rsp_ready_in} = 2'h1;
        repeat (2) @(posedge clock_in) #1;
        rsp_ready_in = 0;
        chk("empty", 0, rsp_valid_out);
        acc(1, ia(2, 3, 0), 32'h0004_c041);
        acc(0, 24'h80_0c94, 0);
        chk("pio", 32'h0000_7f7f, rd);
        chk("ptime", {5'h01, 5'h10, 5'h02, 5'h02, 5'h10, 5'h03}, tm);
        acc(1, 24'h80_0c94, 32'h0000_1234);
        chk("pwr", {10'h008, 1'h1, 16'h1234}, {pio_cs_out, ext_write_out, ext_wdata_out});
        acc(0, 24'h41_fffc, 0);
        chk("bbram", 8'ha5, rd[7:0]);
        chk("bbcs", 4, cs);
        acc(1, 24'h20_0000, 32'h0000_1234);
        chk("romwr", 0, ext_strobe_out);
        acc(0, 24'h20_0000, 0);
        chk("rom1", 2, cs);
        acc(1, ia(4, 0, 0), 1);
        acc(0, 24'h20_0000, 0);
        chk("rom0", 1, cs);
        acc(1, ia(5, 0, 0), 1);
        chk("spare_on", 1, spare_out);
        dma_req_n_in[0] = 0;
        repeat (4) @(posedge clock_in) #1;
        dma_req_n_in[0] = 1;
        for (int i = 0; i < 5 && !dma_preempt_out[0]; i++) @(posedge clock_in) #1;
        chk("preempt", 1, dma_preempt_out[0]);
        acc(1, ia(0, 0, 0), 32'h0800_0000);
        dma_req_n_in[0] = 0;
        @(posedge clock_in) #1 dma_req_n_in[0] = 1;
        #1 chk("preempt_live", 1, dma_preempt_out[0]);
        dma_tc_req_in = 1;
        @(posedge clock_in) #1 dma_tc_req_in = 0;
        chk("tc", 1, tc_out);
        end_of_test();
    end
endmodule : pbc_ctrl_bench
`default_nettype wire
